// ### verif/ddr_controller_config_and_region_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_controller_config_and_region_map_tb;
	import ddr_cfg_pkg::*;
	logic ref_clk, reset, controller_soft_reset_n, force_low_priority, two_t_mode;
	logic req_valid, req_write, req_high_priority;
	logic [2:0] controller_operating_mode, low_priority_entry_count, refresh_burst_length;
	logic [CNT_W-1:0] refresh_interval, mode_command_delay, mode_register_set_delay;
	logic [CNT_W-1:0] hp_critical_min, lp_critical_min, wr_critical_min;
	logic [NUM_RANKS-1:0] odt_read_enable, odt_write_enable, mem_odt_q;
	logic [MR_COUNT*MR_W-1:0] mode_values;
	logic [COL_BITS*MAP_W-1:0] column_map;
	logic [BANK_BITS*MAP_W-1:0] bank_map;
	logic [ROW_BITS*MAP_W-1:0] row_map;
	logic [NUM_MASTERS*4-1:0] region_mapping_control;
	logic [NUM_MASTERS*SYS_AW-1:0] master_addr;
	logic [SYS_AW-1:0] sys_addr;
	logic [ROW_BITS-1:0] mem_size_mask, mem_addr_q;
	logic req_ready_q, ecc_enable_q, init_done_q, critical_q;
	logic [2:0] mem_cmd_q;
	logic [BANK_BITS-1:0] mem_bank_q;
	logic [NUM_SLICES-1:0] slice_enable_q;
	logic [3:0] lp_used_q, hp_used_q, win_hit_q;
	logic [NUM_MASTERS*MEM_AW-1:0] win_mem_addr_q;
	logic [7:0] mrs_count, ref_count;
	logic [15:0] mrs_gap;
	int err_count = 0;
	int total_checks = 0;

	ddr_controller_config u_ddr_controller_config (.ref_clk, .reset, .controller_soft_reset_n,
		.controller_operating_mode, .low_priority_entry_count, .force_low_priority,
		.refresh_burst_length, .refresh_interval, .two_t_mode, .odt_read_enable,
		.odt_write_enable, .mode_command_delay, .mode_register_set_delay, .mode_values,
		.column_map, .bank_map, .row_map, .hp_critical_min, .lp_critical_min, .wr_critical_min,
		.region_mapping_control, .master_addr, .sys_addr, .req_valid, .req_write,
		.req_high_priority, .mem_size_mask, .req_ready_q, .mem_cmd_q, .mem_addr_q, .mem_bank_q,
		.mem_odt_q, .ecc_enable_q, .slice_enable_q, .init_done_q, .lp_used_q, .hp_used_q,
		.critical_q, .win_hit_q, .win_mem_addr_q);
	ddr_mem_model u_ddr_mem_model (.ref_clk, .reset, .mem_cmd_q, .mrs_count, .ref_count,
		.mrs_gap);

	// =====================================================
	// shared helpers
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// which: 0 init done, 1 ready, 2 command c seen; bounded so a hang ends the run
	task automatic wait_for(input int which, input logic [2:0] c);
		int n;
		n = 0;
		while (!(which == 0 ? init_done_q === 1'b1 : which == 1 ? req_ready_q === 1'b1
				: mem_cmd_q === c) && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 2000) begin
			err_count++;
			$display("MISMATCH at %0t: wait ran out", $time);
			summarize();
		end
	endtask

	// =====================================================
	// scenarios
	task automatic scen_init(input logic [7:0] exp_mrs);
		repeat (3) @(negedge ref_clk);
		check(init_done_q, 1'b0);
		check(mem_cmd_q, CMD_NOP);
		controller_soft_reset_n = 1'b1;
		wait_for(0, CMD_NOP);
		check(mrs_count, exp_mrs);
		check(mrs_gap, mode_command_delay + mode_register_set_delay + 16'h_0002);
		check(ecc_enable_q, 1'b1);
		check(slice_enable_q, 5'h_1F);
	endtask

	task automatic scen_window();
		region_mapping_control = 16'h_8301;
		master_addr = {32'h_D000_0010, 32'h_B123_4567, 32'h_A000_0001, 32'h_9FFF_FFFF};
		repeat (2) @(negedge ref_clk);
		check(win_hit_q, 4'b1110);
		check(win_mem_addr_q[MEM_AW+:MEM_AW], {3'h_2, 28'h_000_0001});
		check(win_mem_addr_q[2*MEM_AW+:MEM_AW], {3'h_5, 28'h_123_4567});
		check(win_mem_addr_q[3*MEM_AW+:MEM_AW], {3'h_7, 28'h_000_0010});
		master_addr[31:0] = 32'h_C0AB_CDEF;
		master_addr[63:32] = 32'h_D000_0004;
		repeat (2) @(negedge ref_clk);
		check(win_hit_q[0], 1'b1);
		check(win_mem_addr_q[MEM_AW+:MEM_AW], {3'h_5, 28'h_000_0004});
		check(win_mem_addr_q[MEM_AW-1:0], {3'h_2, 28'h_0AB_CDEF});
	endtask

	// request held from a falling edge until the rising edge that sees ready
	task automatic scen_req(input logic wr, input logic [31:0] a, input logic [2:0] bk,
		input logic [15:0] row);
		req_write = wr;
		sys_addr = a;
		req_high_priority = 1'b1;
		req_valid = 1'b1;
		wait_for(1, CMD_NOP);
		@(posedge ref_clk);
		@(negedge ref_clk);
		req_valid = 1'b0;
		check(hp_used_q, 4'h_0);
		check(lp_used_q <= 4'h_2, 1'b1);
		wait_for(2, wr ? CMD_WR : CMD_RD);
		check(mem_bank_q, bk);
		check(mem_addr_q, row);
		check(critical_q, 1'b0);
		check(mem_odt_q, wr ? odt_write_enable : odt_read_enable);
	endtask

	task automatic scen_refresh(input logic [2:0] b);
		logic [7:0] start;
		refresh_burst_length = b;
		wait_for(2, CMD_REF);
		repeat (60) @(negedge ref_clk);
		start = ref_count;
		wait_for(2, CMD_REF);
		check(mem_cmd_q, CMD_REF);
		repeat (60) @(negedge ref_clk);
		check(ref_count - start, {5'h_00, b} + 8'h_01);
	endtask

	// single refresh: in 1T the next cycle would be idle
	task automatic scen_two_t();
		two_t_mode = 1'b1;
		wait_for(2, CMD_REF);
		@(negedge ref_clk);
		check(mem_cmd_q, CMD_REF);
		repeat (10) @(negedge ref_clk);
		two_t_mode = 1'b0;
	endtask

	// =====================================================
	// clock, reset and main sequence
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial begin
		reset = 1'b1;
		controller_soft_reset_n = 1'b0;
		controller_operating_mode = 3'h_5;
		low_priority_entry_count = 3'h_1;
		force_low_priority = 1'b1;
		refresh_burst_length = 3'h_0;
		refresh_interval = 16'h_0190;
		two_t_mode = 1'b0;
		odt_read_enable = 2'b01;
		odt_write_enable = 2'b10;
		mode_command_delay = 16'h_0004;
		mode_register_set_delay = 16'h_0003;
		mode_values = 64'h_0004_0003_0002_0001;
		column_map = 40'h_33_3333_3000;
		bank_map = 12'h_AAA;
		row_map = 64'h_FFF9_9999_9999_9999;
		hp_critical_min = 16'h_0010;
		lp_critical_min = 16'h_0020;
		wr_critical_min = 16'h_0030;
		region_mapping_control = 16'h_1111;
		master_addr = '0;
		sys_addr = 32'h_0000_0000;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_high_priority = 1'b0;
		mem_size_mask = 16'h_1FFF;
		repeat (12) @(negedge ref_clk);
		reset = 1'b0;
		scen_init(8'h_04);
		scen_window();
		scen_req(1'b0, 32'h_0000_5000, 3'h_5, 16'h_0000);
		scen_req(1'b1, 32'h_2123_B000, 3'h_3, 16'h_0247);
		scen_refresh(3'h_7);
		scen_refresh(3'h_0);
		scen_two_t();
		controller_soft_reset_n = 1'b0;
		scen_init(8'h_08);
		summarize();
	end
endmodule
`default_nettype wire

// ### verif/ddr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// memory side: counts mode loads and refreshes, measures load spacing
module ddr_mem_model
	import ddr_cfg_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	input  wire logic [2:0]           mem_cmd_q,
	output var  logic [7:0]           mrs_count,
	output var  logic [7:0]           ref_count,
	output var  logic [15:0]          mrs_gap
);
	logic [15:0] since_q;

	// counts every refresh cycle, so only meaningful in 1T mode
	always @(posedge ref_clk) begin
		if (reset) begin
			mrs_count <= 8'h_00;
			ref_count <= 8'h_00;
			mrs_gap <= 16'h_0000;
			since_q <= 16'h_0000;
		end else if (mem_cmd_q == CMD_MRS) begin
			mrs_count <= mrs_count + 8'h_01;
			mrs_gap <= since_q + 16'h_0001;
			since_q <= 16'h_0000;
		end else begin
			since_q <= since_q + 16'h_0001;
			if (mem_cmd_q == CMD_REF) begin
				ref_count <= ref_count + 8'h_01;
			end
		end
	end
endmodule
`default_nettype wire

// ### verilog/ddr_cfg_pkg.sv
package ddr_cfg_pkg;
	// =====================================================
	// widths
	localparam int SYS_AW        = 32;
	localparam int MAP_W         = 4;
	localparam int COL_BITS      = 10;
	localparam int BANK_BITS     = 3;
	localparam int ROW_BITS      = 16;
	localparam int MEM_AW        = 31;
	localparam int DQ_W          = 36;
	localparam int SLICE_W       = 8;
	localparam int LAST_SLICE_W  = 4;
	localparam int NUM_SLICES    = 5;
	localparam int STORE_DEPTH   = 8;
	localparam int CNT_W         = 16;
	localparam int MR_COUNT      = 4;
	localparam int MR_W          = 16;
	localparam int NUM_RANKS     = 2;
	localparam int NUM_MASTERS   = 4;
	localparam int REGION_W      = 3;
	localparam int WIN_LOW_BITS  = 28;
	// =====================================================
	// address map bases
	localparam int COL_BASE      = 2;
	localparam int COL_FIRST     = 3;
	localparam int BANK_BASE     = 2;
	localparam int BANK_FIRST_SRC = 10;
	localparam int ROW_BASE      = 6;
	localparam int ROW_FIRST_SRC = 9;
	localparam logic [MAP_W-1:0] MAP_UNUSED = 4'h_F;
	// =====================================================
	// mode values
	localparam logic [2:0] OPMODE_ECC = 3'h_5;
	localparam logic [3:0] REGION_MODE_MAX = 4'h_C;
	localparam logic [3:0] WIN_SPACE_BASE = 4'h_A;
	localparam logic [3:0] WIN_SPACE_LAST = 4'h_D;
	// =====================================================
	// mode register load sequencer states
	typedef enum logic [1:0] {
		MRS_IDLE = 2'b00,
		MRS_ISSUE = 2'b01,
		MRS_WAIT = 2'b11,
		MRS_DONE = 2'b10
	} mrs_state_t;
	// memory command codes
	typedef enum logic [2:0] {
		CMD_NOP = 3'h_0,
		CMD_MRS = 3'h_1,
		CMD_REF = 3'h_2,
		CMD_RD  = 3'h_3,
		CMD_WR  = 3'h_4
	} cmd_t;
endpackage

// ### verilog/ddr_controller_config.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_controller_config
	import ddr_cfg_pkg::*;
(
	input  wire logic                             ref_clk,
	input  wire logic                             reset,
	input  wire logic                             controller_soft_reset_n,
	input  wire logic [2:0]                       controller_operating_mode,
	input  wire logic [2:0]                       low_priority_entry_count,
	input  wire logic                             force_low_priority,
	input  wire logic [2:0]                       refresh_burst_length,
	input  wire logic [CNT_W-1:0]                 refresh_interval,
	input  wire logic                             two_t_mode,
	input  wire logic [NUM_RANKS-1:0]             odt_read_enable,
	input  wire logic [NUM_RANKS-1:0]             odt_write_enable,
	input  wire logic [CNT_W-1:0]                 mode_command_delay,
	input  wire logic [CNT_W-1:0]                 mode_register_set_delay,
	input  wire logic [MR_COUNT*MR_W-1:0]         mode_values,
	input  wire logic [COL_BITS*MAP_W-1:0]        column_map,
	input  wire logic [BANK_BITS*MAP_W-1:0]       bank_map,
	input  wire logic [ROW_BITS*MAP_W-1:0]        row_map,
	input  wire logic [CNT_W-1:0]                 hp_critical_min,
	input  wire logic [CNT_W-1:0]                 lp_critical_min,
	input  wire logic [CNT_W-1:0]                 wr_critical_min,
	input  wire logic [NUM_MASTERS*4-1:0]         region_mapping_control,
	input  wire logic [NUM_MASTERS*SYS_AW-1:0]    master_addr,
	input  wire logic [SYS_AW-1:0]                sys_addr,
	input  wire logic                             req_valid,
	input  wire logic                             req_write,
	input  wire logic                             req_high_priority,
	input  wire logic [ROW_BITS-1:0]              mem_size_mask,
	output logic                                  req_ready_q,
	output logic [2:0]                            mem_cmd_q,
	output logic [ROW_BITS-1:0]                   mem_addr_q,
	output logic [BANK_BITS-1:0]                  mem_bank_q,
	output logic [NUM_RANKS-1:0]                  mem_odt_q,
	output logic                                  ecc_enable_q,
	output logic [NUM_SLICES-1:0]                 slice_enable_q,
	output logic                                  init_done_q,
	output logic [3:0]                            lp_used_q,
	output logic [3:0]                            hp_used_q,
	output logic                                  critical_q,
	output logic [NUM_MASTERS-1:0]                win_hit_q,
	output logic [NUM_MASTERS*MEM_AW-1:0]         win_mem_addr_q
);
	// =====================================================
	// soft reset
	logic ctl_rst;
	assign ctl_rst = reset | ~controller_soft_reset_n;

	// =====================================================
	// address mapping: each mapped bit picks base + field; the low 3 column bits are fixed
	function automatic logic [4:0] src_bit(input int base, input logic [MAP_W-1:0] f);
		return 5'(base + int'(f));
	endfunction

	logic [COL_BITS-1:0]  col_w;
	logic [BANK_BITS-1:0] bank_w;
	logic [ROW_BITS-1:0]  row_w;
	genvar gi;
	generate
		for (gi = 0; gi < COL_BITS; gi++) begin : g_col
			if (gi < COL_FIRST) begin : g_low
				assign col_w[gi] = sys_addr[gi + COL_BASE];
			end else begin : g_map
				assign col_w[gi] = (column_map[gi*MAP_W +: MAP_W] == MAP_UNUSED) ? 1'b0 :
					sys_addr[src_bit(COL_BASE + gi - COL_FIRST, column_map[gi*MAP_W +: MAP_W])];
			end
		end
		for (gi = 0; gi < BANK_BITS; gi++) begin : g_bank
			assign bank_w[gi] = sys_addr[src_bit(BANK_BASE + gi, bank_map[gi*MAP_W +: MAP_W])];
		end
		for (gi = 0; gi < ROW_BITS; gi++) begin : g_row
			// unused row fields leave the bit low so a small part mirrors
			assign row_w[gi] = (row_map[gi*MAP_W +: MAP_W] == MAP_UNUSED) ? 1'b0 :
				sys_addr[src_bit(ROW_BASE + gi, row_map[gi*MAP_W +: MAP_W])] & mem_size_mask[gi];
		end
	endgenerate

	// =====================================================
	// ecc and data slices
	always_ff @(posedge ref_clk) begin
		if (ctl_rst) begin
			ecc_enable_q   <= 1'b0;
			slice_enable_q <= '0;
		end else begin
			ecc_enable_q   <= (controller_operating_mode == OPMODE_ECC);
			slice_enable_q <= {(controller_operating_mode == OPMODE_ECC), 4'h_F};
		end
	end

	// =====================================================
	// mode register load
	mrs_state_t         mrs_q;
	logic [1:0]         mr_idx_q;
	logic [CNT_W:0]     mrs_wait_q;
	always_ff @(posedge ref_clk) begin
		if (ctl_rst) begin
			mrs_q      <= MRS_IDLE;
			mr_idx_q   <= '0;
			mrs_wait_q <= '0;
		end else begin
			unique case (mrs_q)
				MRS_IDLE: mrs_q <= MRS_ISSUE;
				MRS_ISSUE: begin
					mrs_wait_q <= (CNT_W+1)'(mode_command_delay) + (CNT_W+1)'(mode_register_set_delay);
					mrs_q      <= MRS_WAIT;
				end
				MRS_WAIT: begin
					if (mrs_wait_q != '0) begin
						mrs_wait_q <= mrs_wait_q - 1'b1;
					end else if (mr_idx_q == 2'(MR_COUNT - 1)) begin
						mrs_q <= MRS_DONE;
					end else begin
						mr_idx_q <= mr_idx_q + 1'b1;
						mrs_q    <= MRS_ISSUE;
					end
				end
				MRS_DONE: mrs_q <= MRS_DONE;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (ctl_rst) begin
			init_done_q <= 1'b0;
		end else begin
			init_done_q <= (mrs_q == MRS_DONE);
		end
	end

	// =====================================================
	// transaction store occupancy
	logic [3:0] lp_cap;
	logic       is_low;
	logic       take;
	logic       cmd_slot;
	logic       rw_issue;
	assign lp_cap = (low_priority_entry_count == 3'h_0) ? 4'h_1 : {1'b0, low_priority_entry_count};
	assign is_low = force_low_priority | ~req_high_priority;
	assign take   = req_valid & req_ready_q;
	always_ff @(posedge ref_clk) begin
		if (ctl_rst) begin
			lp_used_q <= '0;
			hp_used_q <= '0;
		end else begin
			// only a read or write retires an entry, low queue first; refresh slots do not
			lp_used_q <= 4'(lp_used_q + (take & is_low) - (rw_issue & (lp_used_q != 0)));
			hp_used_q <= 4'(hp_used_q + (take & ~is_low) -
				(rw_issue & (lp_used_q == 0) & (hp_used_q != 0)));
		end
	end
	always_ff @(posedge ref_clk) begin
		if (ctl_rst) begin
			req_ready_q <= 1'b0;
		end else begin
			req_ready_q <= init_done_q & (is_low ? (lp_used_q < lp_cap) :
				(hp_used_q < 4'(STORE_DEPTH) - lp_cap));
		end
	end

	// =====================================================
	// starvation ageing
	logic [CNT_W-1:0] age_q;
	always_ff @(posedge ref_clk) begin
		if (ctl_rst || (lp_used_q == 0 && hp_used_q == 0) || cmd_slot) begin
			age_q <= '0;
		end else if (age_q != '1) begin
			age_q <= age_q + 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (ctl_rst) begin
			critical_q <= 1'b0;
		end else begin
			critical_q <= (lp_used_q != 0) ? (age_q >= (req_write ? wr_critical_min : lp_critical_min)) :
				(hp_used_q != 0) && (age_q >= hp_critical_min);
		end
	end

	// =====================================================
	// refresh timer and burst
	logic [CNT_W-1:0] ref_tmr_q;
	logic [3:0]       ref_left_q;
	always_ff @(posedge ref_clk) begin
		if (ctl_rst || ref_tmr_q >= refresh_interval) begin
			ref_tmr_q <= '0;
		end else begin
			ref_tmr_q <= ref_tmr_q + 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (ctl_rst) begin
			ref_left_q <= '0;
		end else if (init_done_q && ref_tmr_q >= refresh_interval) begin
			ref_left_q <= 4'(ref_left_q + refresh_burst_length + 1'b1);
		end else if (cmd_slot && ref_left_q != 0 && mem_cmd_q == CMD_NOP) begin
			ref_left_q <= ref_left_q - 1'b1;
		end
	end

	// =====================================================
	// command issue with 1T/2T pacing
	logic hold_q;
	assign cmd_slot = init_done_q & ~hold_q & ((ref_left_q != 0) | (lp_used_q != 0) | (hp_used_q != 0));
	assign rw_issue = cmd_slot & (ref_left_q == 0);
	always_ff @(posedge ref_clk) begin
		if (ctl_rst) begin
			hold_q <= 1'b0;
		end else begin
			hold_q <= two_t_mode & ~hold_q & (cmd_slot | (mrs_q == MRS_ISSUE));
		end
	end
	always_ff @(posedge ref_clk) begin
		if (ctl_rst) begin
			mem_cmd_q  <= CMD_NOP;
			mem_addr_q <= '0;
			mem_bank_q <= '0;
			mem_odt_q  <= '0;
		end else if (hold_q) begin
			mem_cmd_q <= mem_cmd_q;
		end else if (mrs_q == MRS_ISSUE) begin
			mem_cmd_q  <= CMD_MRS;
			mem_addr_q <= mode_values[mr_idx_q*MR_W +: MR_W];
			mem_bank_q <= 3'(mr_idx_q);
			mem_odt_q  <= '0;
		end else if (cmd_slot && ref_left_q != 0 && mem_cmd_q == CMD_NOP) begin
			mem_cmd_q <= CMD_REF;
			mem_odt_q <= '0;
		end else if (cmd_slot && ref_left_q == 0) begin
			mem_cmd_q  <= req_write ? CMD_WR : CMD_RD;
			mem_addr_q <= row_w;
			mem_bank_q <= bank_w;
			mem_odt_q  <= req_write ? odt_write_enable : odt_read_enable;
		end else begin
			mem_cmd_q <= CMD_NOP;
			mem_odt_q <= '0;
		end
	end

	// =====================================================
	// per master region windows
	generate
		for (gi = 0; gi < NUM_MASTERS; gi++) begin : g_win
			region_window_map u_map (
				.ref_clk     (ref_clk),
				.reset       (reset),
				.region_mode (region_mapping_control[gi*4 +: 4]),
				.master_addr (master_addr[gi*SYS_AW +: SYS_AW]),
				.hit_q       (win_hit_q[gi]),
				.mem_addr_q  (win_mem_addr_q[gi*MEM_AW +: MEM_AW])
			);
		end
	endgenerate

	// =====================================================
	// checks
	sequence s_mrs_issue;
		mrs_q == MRS_ISSUE;
	endsequence
	a_ecc_mode: assert property (@(posedge ref_clk) disable iff (ctl_rst)
		controller_operating_mode == OPMODE_ECC |=> ecc_enable_q && slice_enable_q[4])
		else $error("ecc not enabled");
	a_mrs_wait: assert property (@(posedge ref_clk) disable iff (ctl_rst)
		s_mrs_issue |=> mrs_q == MRS_WAIT)
		else $error("mode load spacing skipped");
	a_force_low: assert property (@(posedge ref_clk) disable iff (ctl_rst)
		take && force_low_priority |=> hp_used_q <= $past(hp_used_q))
		else $error("forced low priority ignored");
	a_two_t_hold: assert property (@(posedge ref_clk) disable iff (ctl_rst)
		two_t_mode && $changed(mem_cmd_q) && mem_cmd_q != CMD_NOP |=> $stable(mem_cmd_q))
		else $error("2T command not held");
	a_odt_idle: assert property (@(posedge ref_clk) disable iff (ctl_rst)
		mem_cmd_q == CMD_REF || mem_cmd_q == CMD_MRS |-> mem_odt_q == '0)
		else $error("odt on non data command");
	a_store_limit: assert property (@(posedge ref_clk) disable iff (ctl_rst)
		lp_used_q + hp_used_q <= 5'(STORE_DEPTH))
		else $error("store overfilled");
	a_soft_reset: assert property (@(posedge ref_clk) disable iff (reset)
		!controller_soft_reset_n |=> mem_cmd_q == CMD_NOP && !init_done_q)
		else $error("soft reset not held");
	a_refresh_due: assert property (@(posedge ref_clk) disable iff (ctl_rst)
		init_done_q && ref_tmr_q >= refresh_interval |=> ref_left_q != 0)
		else $error("refresh not scheduled");
endmodule
`default_nettype wire

// ### verilog/region_window_map.sv
`timescale 1ns/1ps
`default_nettype none
module region_window_map
	import ddr_cfg_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    reset,
	input  wire logic [3:0]              region_mode,
	input  wire logic [SYS_AW-1:0]       master_addr,
	output logic                         hit_q,
	output logic [MEM_AW-1:0]            mem_addr_q
);
	logic [1:0]          space;
	logic [REGION_W-1:0] region;

	// =====================================================
	// window space to region
	function automatic logic [REGION_W-1:0] pick_region(input logic [3:0] m,
		input logic [1:0] s);
		logic [REGION_W-1:0] r;
		r = {1'b0, s};
		unique case (m)
			4'h_0: r = 3'({1'b0, s} + 3'd2);
			4'h_3: r = 3'(s + 3'd4);
			4'h_7: r = s[1] ? 3'({1'b0, s} + 3'd2) : {1'b0, s};
			4'h_8: r = s[1] ? 3'({1'b0, s} + 3'd4) : {1'b0, s};
			default: r = {1'b0, s};
		endcase
		return r;
	endfunction

	assign space  = 2'(master_addr[WIN_LOW_BITS+1:WIN_LOW_BITS] + 2'd2);
	assign region = pick_region(region_mode, space);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			hit_q      <= 1'b0;
			mem_addr_q <= '0;
		end else begin
			// region n at n * 256 MB, low bits pass unchanged
			hit_q      <= (master_addr[SYS_AW-1:WIN_LOW_BITS] >= WIN_SPACE_BASE) &&
				(master_addr[SYS_AW-1:WIN_LOW_BITS] <= WIN_SPACE_LAST);
			mem_addr_q <= {region, master_addr[WIN_LOW_BITS-1:0]};
		end
	end

	a_region_low_bits: assert property (@(posedge ref_clk) disable iff (reset)
		1 |=> mem_addr_q[WIN_LOW_BITS-1:0] == $past(master_addr[WIN_LOW_BITS-1:0]))
		else $error("window low bits altered");
	a_mode_one_map: assert property (@(posedge ref_clk) disable iff (reset)
		region_mode == 4'h_1 |=> mem_addr_q[MEM_AW-1:WIN_LOW_BITS] ==
		3'($past(master_addr[WIN_LOW_BITS+1:WIN_LOW_BITS]) + 2'd2))
		else $error("mode one region wrong");
endmodule
`default_nettype wire
